/* File: spi_cfg_pkg.sv */
// constants, register map, field positions and state codes of the serial
// configuration port and lo setup sequencer.
// assumes a 40 mhz system clock and a serial clock that runs only in frames.
//
// Functional notes
// (RULE_01) after the last pll write, run a vco band calibration of about 200 us.
// (RULE_02) pll lock status reads back in bit 0 of the lock status register.
// (RULE_03) the same lock status drives a dedicated lock indicator pin.
// (RULE_04) host writes every other pll register first, integer low byte last.
// (RULE_05) writing the integer divider low byte starts the vco calibration.
// (RULE_06) host writes the fixed seven register sequence to select external lo.
// (RULE_07) host clears bits 0 to 2 of the lo enables register to run divider.
// (RULE_08) bits 3 to 6 enable i/q drivers and i/q predrivers separately.
// (RULE_09) host sets the lo output gate only after lock or external lo.
// (RULE_10) host enables rf and if blocks only after the lo output gate.
// (RULE_11) four lines: clock, two-way data, data out, active-low select.
// (RULE_12) frame starts at the first rising clock after select falls.
// (RULE_13) while select is high all clock and data activity is ignored.
// (RULE_14) frame is read/write bit, 16 address bits, then 8 data bits.
// (RULE_15) address and data are shifted most significant bit first.
// (RULE_16) both io level bits set select 3.3 v levels, default 1.8 v.
// (RULE_17) the register space is writable and readable over the serial port; the code drops writes to the lock status register.
// (RULE_18) the two rf input select pins are active-high controls.
// (RULE_19) the sleep pin is active high and holds sleep mode.
// (RULE_20) 4-wire mode reads on data out; 3-wire mode reads on two-way data.
// (RULE_21) high means read; output changes on falling, input sampled on rising.
// (RULE_22) 3-wire or 4-wire choice is a static configuration input.

package spi_cfg_pkg;

    // ***********************************************************************
    // register map
    // ***********************************************************************
    localparam int NUM_REGS = 12;
    localparam logic [15:0] ADDR_IO_LEVEL_LO = 16'h0020;
    localparam logic [15:0] ADDR_LO_ENABLES = 16'h0090;
    localparam logic [15:0] ADDR_PLL_POWER = 16'h1021;
    localparam logic [15:0] ADDR_INT_LOW = 16'h1200;
    localparam logic [15:0] ADDR_FB_DIV = 16'h120b;
    localparam logic [15:0] ADDR_VCO_SEL = 16'h1217;
    localparam logic [15:0] ADDR_CAL_CTL = 16'h121f;
    localparam logic [15:0] ADDR_PFD_CP = 16'h122d;
    localparam logic [15:0] ADDR_VCO_ADJ = 16'h1240;
    localparam logic [15:0] ADDR_LOCK_STATUS = 16'h124d;
    localparam logic [15:0] ADDR_IO_LEVEL_HI = 16'h1401;
    localparam logic [15:0] ADDR_LO_OUT_CTL = 16'h1414;
    localparam logic [3:0] IDX_IO_LEVEL_LO = 4'h0;
    localparam logic [3:0] IDX_LO_ENABLES = 4'h1;
    localparam logic [3:0] IDX_PLL_POWER = 4'h2;
    localparam logic [3:0] IDX_INT_LOW = 4'h3;
    localparam logic [3:0] IDX_FB_DIV = 4'h4;
    localparam logic [3:0] IDX_VCO_SEL = 4'h5;
    localparam logic [3:0] IDX_CAL_CTL = 4'h6;
    localparam logic [3:0] IDX_PFD_CP = 4'h7;
    localparam logic [3:0] IDX_VCO_ADJ = 4'h8;
    localparam logic [3:0] IDX_LOCK_STATUS = 4'h9;
    localparam logic [3:0] IDX_IO_LEVEL_HI = 4'ha;
    localparam logic [3:0] IDX_LO_OUT_CTL = 4'hb;
    localparam logic [7:0] RST_DEFAULT = 8'h00;
    localparam logic [7:0] RST_LO_ENABLES = 8'h07;

    // ***********************************************************************
    // field positions
    // ***********************************************************************
    localparam int BIT_QUAD_BIAS = 0;
    localparam int BIT_DIV_BUF = 1;
    localparam int BIT_QUAD_DIV = 2;
    localparam int BIT_DRV_I = 3;
    localparam int BIT_DRV_Q = 4;
    localparam int BIT_PREDRV_I = 5;
    localparam int BIT_PREDRV_Q = 6;
    localparam int BIT_LO_GATE = 6;
    localparam int OUT_DIV_MSB = 4;
    localparam int BIT_IO_LVL_LO = 0;
    localparam int BIT_IO_LVL_HI = 4;
    localparam int BIT_LOCK = 0;
    localparam int BIT_CAL_DISABLE = 6;

    // ***********************************************************************
    // frame layout and timing
    // ***********************************************************************
    localparam logic [4:0] CNT_RW = 5'h00;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h10;
    localparam logic [4:0] CNT_DATA_FIRST = 5'h11;
    localparam logic [4:0] CNT_FRAME_LAST = 5'h18;
    localparam logic [4:0] CNT_FRAME_DONE = 5'h19;
    localparam int CAL_TIME_US = 200;
    localparam int SYS_CLK_MHZ = 40;
    localparam int CAL_CYCLES_DEF = CAL_TIME_US * SYS_CLK_MHZ;
    localparam int CAL_CNT_W = 14;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CAL = 3'b010,
        ST_TRACK = 3'b100
    } cal_state_e;

    // address to register index, hit flag in the top bit
    function automatic logic [4:0] reg_index(input logic [15:0] a);
        logic [4:0] r;
        r = 5'h00;
        if (a == ADDR_IO_LEVEL_LO) r = {1'b1, IDX_IO_LEVEL_LO};
        else if (a == ADDR_LO_ENABLES) r = {1'b1, IDX_LO_ENABLES};
        else if (a == ADDR_PLL_POWER) r = {1'b1, IDX_PLL_POWER};
        else if (a == ADDR_INT_LOW) r = {1'b1, IDX_INT_LOW};
        else if (a == ADDR_FB_DIV) r = {1'b1, IDX_FB_DIV};
        else if (a == ADDR_VCO_SEL) r = {1'b1, IDX_VCO_SEL};
        else if (a == ADDR_CAL_CTL) r = {1'b1, IDX_CAL_CTL};
        else if (a == ADDR_PFD_CP) r = {1'b1, IDX_PFD_CP};
        else if (a == ADDR_VCO_ADJ) r = {1'b1, IDX_VCO_ADJ};
        else if (a == ADDR_LOCK_STATUS) r = {1'b1, IDX_LOCK_STATUS};
        else if (a == ADDR_IO_LEVEL_HI) r = {1'b1, IDX_IO_LEVEL_HI};
        else if (a == ADDR_LO_OUT_CTL) r = {1'b1, IDX_LO_OUT_CTL};
        return r;
    endfunction : reg_index

endpackage : spi_cfg_pkg

/* File: spi_config_lo_sequencer.sv */
// serial configuration port, register file and lo setup sequencer.
// the frame logic and the register file run on the host's serial clock;
// the calibration timer, lock reporting and control outputs run on the
// system clock. writes cross by a toggle with the word held stable.
`timescale 1ns/1ps

module spi_config_lo_sequencer
    import spi_cfg_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
    input wire logic i_clk_sys, // system clock, 40 mhz
    input wire logic i_nrst, // asynchronous reset, active low
    input wire logic i_ce, // clock enable for the system domain
    input wire logic i_sclk, // serial clock from the host
    input wire logic i_cs_n, // serial select, active low
    input wire logic i_sdio, // two-way data, input side
    output logic o_sdio, // two-way data, output side
    output logic o_sdio_oe, // two-way data, drive enable
    output logic o_serial_data_out, // read data line in 4-wire mode
    input wire logic i_four_wire_mode, // static: 1 = 4-wire, 0 = 3-wire
    input wire logic i_loop_lock, // loop settled, from the analog lock detector
    input wire logic i_rf_input_select_0, // rf input select pin 0, active high
    input wire logic i_rf_input_select_1, // rf input select pin 1, active high
    input wire logic i_sleep, // sleep pin, active high
    output logic [1:0] o_rf_path_sel, // synchronised rf input selects
    output logic o_sleep_mode, // sleep mode request
    output logic o_lock_indicator_pin, // pll lock indicator pin
    output logic o_cal_busy, // vco band calibration running
    output logic o_quad_bias_gen_ctl, // quadrature bias generator control
    output logic o_divider_path_buffer_ctl, // divider path buffer control
    output logic o_quadrature_divider_ctl, // quadrature divider control
    output logic o_i_path_driver_en, // i lo driver enable
    output logic o_q_path_driver_en, // q lo driver enable
    output logic o_i_path_predriver_en, // i lo predriver enable
    output logic o_q_path_predriver_en, // q lo predriver enable
    output logic o_lo_output_gate, // lo output gate
    output logic [4:0] o_lo_out_div, // lo output divide ratio field
    output logic o_io_level_3v3 // 1 = 3.3 v logic levels
);

    // ***********************************************************************
    // state types
    // ***********************************************************************
    typedef struct packed {
        logic [4:0] cnt;
        logic [15:0] sr;
        logic rw;
        logic [15:0] addr;
        logic [7:0] rd;
    } frame_s;

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;
        logic wr_tgl;
        logic [3:0] wr_idx;
        logic [7:0] wr_data;
    } regfile_s;

    typedef struct packed {
        logic sdio_bit;
        logic sdo_bit;
        logic sdio_oe;
    } txo_s;

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] shadow;
        logic wr_seen;
        cal_state_e st;
        logic [CAL_CNT_W-1:0] cal_cnt;
        logic lock;
    } sys_s;

    frame_s fr_q;
    frame_s fr_d;
    regfile_s rf_q;
    regfile_s rf_d;
    txo_s tx_q;
    txo_s tx_d;
    sys_s s_q;
    sys_s s_d;

    logic frame_rst;
    logic lock_s;
    logic [15:0] new_addr;
    logic [4:0] rd_hit;
    logic [4:0] wr_hit;
    logic [7:0] wr_byte;
    logic wr_ok;
    logic [4:0] sys_in_s;
    logic wr_tgl_s;
    logic loop_lock_s;
    logic wr_new;
    logic cal_dis;

    // ***********************************************************************
    // serial clock domain: frame decode and register file
    // ***********************************************************************

    // select high holds the frame logic in reset, so clock and data are ignored
    assign frame_rst = ~i_nrst | i_cs_n; // [RULE_13]

    // lock status enters the serial domain through its own synchroniser
    sync3 #(.W(1)) u_lock_sync (
        .i_clk(i_sclk),
        .i_nrst(i_nrst),
        .i_ce(1'b1),
        .i_d(s_q.lock),
        .o_q(lock_s)
    );

    // address and data arrive msb first through one shift register
    assign new_addr = {fr_q.sr[14:0], i_sdio}; // [RULE_15]
    assign wr_byte = {fr_q.sr[6:0], i_sdio}; // [RULE_15]
    assign rd_hit = reg_index(new_addr);
    assign wr_hit = reg_index(fr_q.addr);
    // the lock status register is read only; writes to it are dropped
    assign wr_ok = wr_hit[4] && (wr_hit[3:0] != IDX_LOCK_STATUS);

    // rising edge: sample rw, address, data; count saturates so trailing clocks do nothing
    always_comb begin
        fr_d = fr_q;
        rf_d = rf_q;
        fr_d.sr = new_addr; // [RULE_21]
        if (fr_q.cnt != CNT_FRAME_DONE) begin
            fr_d.cnt = fr_q.cnt + 5'h01; // [RULE_12]
        end
        if (fr_q.cnt == CNT_RW) begin
            fr_d.rw = i_sdio; // [RULE_14] [RULE_21]
        end
        if (fr_q.cnt == CNT_ADDR_LAST) begin
            fr_d.addr = new_addr; // [RULE_14]
            if (rd_hit[4] && rd_hit[3:0] == IDX_LOCK_STATUS) begin
                fr_d.rd = {7'h00, lock_s}; // [RULE_02]
            end else if (rd_hit[4]) begin
                fr_d.rd = rf_q.regs[rd_hit[3:0]]; // [RULE_17]
            end else begin
                fr_d.rd = 8'h00;
            end
        end
        if (fr_q.cnt == CNT_FRAME_LAST && !fr_q.rw && wr_ok) begin
            rf_d.regs[wr_hit[3:0]] = wr_byte; // [RULE_17]
            rf_d.wr_idx = wr_hit[3:0];
            rf_d.wr_data = wr_byte;
            rf_d.wr_tgl = ~rf_q.wr_tgl;
        end
    end

    // frame state is cleared by select; the register file only by the reset pin
    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            fr_q <= '0;
        end else begin
            fr_q <= fr_d;
        end
    end

    always_ff @(posedge i_sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rf_q.regs <= '0;
            rf_q.regs[IDX_LO_ENABLES] <= RST_LO_ENABLES;
            rf_q.wr_tgl <= 1'b0;
            rf_q.wr_idx <= 4'h0;
            rf_q.wr_data <= RST_DEFAULT;
        end else begin
            rf_q <= rf_d;
        end
    end

    // falling edge: present read data half a clock period ahead of the host's sampling edge
    always_comb begin
        tx_d = '0;
        if (fr_q.rw && fr_q.cnt >= CNT_DATA_FIRST && fr_q.cnt <= CNT_FRAME_LAST) begin
            if (i_four_wire_mode) begin
                tx_d.sdo_bit = fr_q.rd[3'(CNT_FRAME_LAST - fr_q.cnt)]; // [RULE_20] [RULE_22]
            end else begin
                tx_d.sdio_bit = fr_q.rd[3'(CNT_FRAME_LAST - fr_q.cnt)]; // [RULE_11] [RULE_20]
                tx_d.sdio_oe = 1'b1; // [RULE_11]
            end
        end
    end

    always_ff @(negedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d; // [RULE_21]
        end
    end

    assign o_sdio = tx_q.sdio_bit;
    assign o_sdio_oe = tx_q.sdio_oe;
    assign o_serial_data_out = tx_q.sdo_bit;

    // ***********************************************************************
    // system clock domain: write shadow, calibration and lock
    // ***********************************************************************

    // pins and the write toggle cross through the three stage filter
    sync3 #(.W(5)) u_sys_sync (
        .i_clk(i_clk_sys),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_d({rf_q.wr_tgl, i_loop_lock, i_rf_input_select_1, i_rf_input_select_0, i_sleep}),
        .o_q(sys_in_s)
    );

    assign wr_tgl_s = sys_in_s[4];
    assign loop_lock_s = sys_in_s[3];
    assign wr_new = wr_tgl_s != s_q.wr_seen;
    assign cal_dis = s_q.shadow[IDX_CAL_CTL][BIT_CAL_DISABLE];

    // the write word is held still for a whole frame, far longer than the toggle path,
    // so it is safe to take it once the toggle has arrived
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            ST_IDLE: begin
                s_d.st = ST_IDLE;
            end
            ST_CAL: begin
                if (s_q.cal_cnt == '0) begin
                    s_d.st = ST_TRACK; // [RULE_01]
                end else begin
                    s_d.cal_cnt = s_q.cal_cnt - 1'b1; // [RULE_01]
                end
            end
            ST_TRACK: begin
                s_d.st = ST_TRACK;
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        if (wr_new) begin
            s_d.wr_seen = wr_tgl_s;
            s_d.shadow[rf_q.wr_idx] = rf_q.wr_data;
            // calibration control bit 6 set means the external lo path, no calibration
            if (rf_q.wr_idx == IDX_INT_LOW && !cal_dis) begin
                s_d.st = ST_CAL; // [RULE_05]
                s_d.cal_cnt = CAL_CNT_W'(CAL_CYCLES - 1); // [RULE_01]
            end
        end
        // lock reported only after calibration and while the loop reports settled
        s_d.lock = (s_q.st == ST_TRACK) && loop_lock_s; // [RULE_02] [RULE_03]
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q.shadow <= '0;
            s_q.shadow[IDX_LO_ENABLES] <= RST_LO_ENABLES;
            s_q.wr_seen <= 1'b0;
            s_q.st <= ST_IDLE;
            s_q.cal_cnt <= '0;
            s_q.lock <= 1'b0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // control outputs from flops, busy through a state compare and 3.3 v through an and: shadow, state, lock and pin synchroniser
    assign o_lock_indicator_pin = s_q.lock; // [RULE_03]
    assign o_cal_busy = s_q.st == ST_CAL;
    assign o_quad_bias_gen_ctl = s_q.shadow[IDX_LO_ENABLES][BIT_QUAD_BIAS];
    assign o_divider_path_buffer_ctl = s_q.shadow[IDX_LO_ENABLES][BIT_DIV_BUF];
    assign o_quadrature_divider_ctl = s_q.shadow[IDX_LO_ENABLES][BIT_QUAD_DIV];
    assign o_i_path_driver_en = s_q.shadow[IDX_LO_ENABLES][BIT_DRV_I]; // [RULE_08]
    assign o_q_path_driver_en = s_q.shadow[IDX_LO_ENABLES][BIT_DRV_Q]; // [RULE_08]
    assign o_i_path_predriver_en = s_q.shadow[IDX_LO_ENABLES][BIT_PREDRV_I]; // [RULE_08]
    assign o_q_path_predriver_en = s_q.shadow[IDX_LO_ENABLES][BIT_PREDRV_Q]; // [RULE_08]
    assign o_lo_output_gate = s_q.shadow[IDX_LO_OUT_CTL][BIT_LO_GATE];
    assign o_lo_out_div = s_q.shadow[IDX_LO_OUT_CTL][OUT_DIV_MSB:0];
    // 3.3 v levels need both select bits; either alone leaves 1.8 v
    assign o_io_level_3v3 = s_q.shadow[IDX_IO_LEVEL_LO][BIT_IO_LVL_LO]
        & s_q.shadow[IDX_IO_LEVEL_HI][BIT_IO_LVL_HI]; // [RULE_16]
    assign o_rf_path_sel = sys_in_s[2:1]; // [RULE_18]
    assign o_sleep_mode = sys_in_s[0]; // [RULE_19]

    // ***********************************************************************
    // checks
    // ***********************************************************************

    // a write to the integer low byte arms the full calibration count
    chk_cal_start_arm: assert property ( // [RULE_05]
        @(posedge i_clk_sys) disable iff (!i_nrst || !i_ce)
        (wr_new && rf_q.wr_idx == IDX_INT_LOW && !cal_dis)
        |=> (s_q.st == ST_CAL && s_q.cal_cnt == CAL_CNT_W'(CAL_CYCLES - 1)))
        else $error("calibration not armed by integer low byte write");

    // calibration ends exactly when the count runs out
    chk_cal_end_track: assert property ( // [RULE_01]
        @(posedge i_clk_sys) disable iff (!i_nrst || !i_ce)
        (s_q.st == ST_CAL && s_q.cal_cnt == '0 && !wr_new) |=> s_q.st == ST_TRACK)
        else $error("calibration did not end at terminal count");

    // the lock pin is low in the cycle after any cycle outside tracking
    chk_lock_pin_state: assert property ( // [RULE_03]
        @(posedge i_clk_sys) disable iff (!i_nrst || !i_ce)
        (s_q.st != ST_TRACK) |=> !o_lock_indicator_pin)
        else $error("lock pin high outside tracking");

    // i driver and q predriver enables follow the written lo enables byte
    chk_drv_en_follow: assert property ( // [RULE_08]
        @(posedge i_clk_sys) disable iff (!i_nrst || !i_ce)
        (wr_new && rf_q.wr_idx == IDX_LO_ENABLES)
        |=> (o_q_path_predriver_en == rf_q.wr_data[BIT_PREDRV_Q]
            && o_i_path_driver_en == rf_q.wr_data[BIT_DRV_I]))
        else $error("lo driver enables do not follow write");

    // clearing the high select bit alone falls back to 1.8 v levels
    chk_io_level_both: assert property ( // [RULE_16]
        @(posedge i_clk_sys) disable iff (!i_nrst || !i_ce)
        (wr_new && rf_q.wr_idx == IDX_IO_LEVEL_HI && !rf_q.wr_data[BIT_IO_LVL_HI]) |=> !o_io_level_3v3)
        else $error("3.3 v levels without both select bits");

    // nothing is driven on the two-way line while select is high
    chk_sdio_idle_cs: assert property ( // [RULE_13]
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_cs_n |-> !o_sdio_oe)
        else $error("two-way line driven while deselected");

    // 4-wire mode never turns the two-way line around
    chk_sdo_mode_sel: assert property ( // [RULE_20]
        @(negedge i_sclk) disable iff (frame_rst)
        i_four_wire_mode |-> (!o_sdio_oe && !o_sdio))
        else $error("two-way line driven in 4-wire mode");

    // lock status register read captures the synchronised lock
    chk_lock_reg_read: assert property ( // [RULE_02]
        @(posedge i_sclk) disable iff (frame_rst)
        (fr_q.cnt == CNT_ADDR_LAST && new_addr == ADDR_LOCK_STATUS)
        |=> fr_q.rd == {7'h00, $past(lock_s)})
        else $error("lock status read byte wrong");

    // address arrives msb first: its top bit is the one sampled at the second edge
    chk_addr_msb_first: assert property ( // [RULE_15]
        @(posedge i_sclk) disable iff (frame_rst)
        (fr_q.cnt == CNT_ADDR_LAST) |=> fr_q.addr[15] == $past(i_sdio, 16))
        else $error("address not shifted msb first");

    // a write frame commits its byte and flips the toggle at the last bit;
    // checked at the next serial edge, which lies beyond select going high
    chk_write_commit: assert property ( // [RULE_14]
        @(posedge i_sclk) disable iff (!i_nrst)
        (fr_q.cnt == CNT_FRAME_LAST && !fr_q.rw && wr_ok)
        |=> (rf_q.wr_tgl != $past(rf_q.wr_tgl) && rf_q.regs[rf_q.wr_idx] == rf_q.wr_data))
        else $error("write frame did not commit");

endmodule : spi_config_lo_sequencer

/* File: spi_host_model.sv */
// serial host model: frames of rw bit, 16 address bits and 8 data bits.
// assumes the bench resolves the two-way data line from both enables.
`timescale 1ns/1ps

module spi_host_model (
    output logic o_sclk, // serial clock, still outside frames except in the noise task
    output logic o_cs_n, // select, active low
    output logic o_mosi, // host data onto the two-way line
    output logic o_mosi_en, // host drives the two-way line
    input wire logic i_miso // resolved read data line
);
    // ***********************************************************************
    // frame tasks
    // ***********************************************************************
    initial begin
        o_sclk = 1'b0;
        // select starts low so that reset entry raises the frame reset edge
        o_cs_n = 1'b0;
        o_mosi = 1'b0;
        o_mosi_en = 1'b1;
        #2 o_cs_n = 1'b1;
    end

    // one frame, 15 ns link period; host lets go of the line for read data
    task automatic xfer(input logic rw, input logic [15:0] a, input logic [7:0] wd, output logic [7:0] rd);
        logic [24:0] f;
        f = {rw, a, wd};
        o_cs_n = 1'b0;
        #10;
        for (int i = 24; i >= 0; i--) begin
            o_mosi = f[i];
            o_mosi_en = !(rw && i < 8);
            #7.5 o_sclk = 1'b1;
            if (i < 8) rd[i] = i_miso;
            #7.5 o_sclk = 1'b0;
        end
        #10 o_cs_n = 1'b1;
        o_mosi_en = 1'b1;
        #20;
    endtask : xfer

    // clock and data activity with select high must leave no trace
    task automatic noise();
        for (int i = 0; i < 26; i++) begin
            o_mosi = ~o_mosi;
            #7.5 o_sclk = 1'b1;
            #7.5 o_sclk = 1'b0;
        end
    endtask : noise
endmodule : spi_host_model

/* File: sync3.sv */
// three stage synchroniser with agreement filter, one bit per lane.
// assumes each lane is a level or a toggle that stays put for several clocks.
`timescale 1ns/1ps

module sync3 #(
    parameter int W = 1
) (
    input wire logic i_clk, // destination clock
    input wire logic i_nrst, // asynchronous reset, active low
    input wire logic i_ce, // clock enable, freezes the chain when low
    input wire logic [W-1:0] i_d, // asynchronous levels
    output logic [W-1:0] o_q // filtered levels
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } sync_s;

    sync_s q_q;
    sync_s q_d;

    // a lane only moves once stages two and three agree; stage one feeds stage two alone
    always_comb begin
        q_d = q_q;
        q_d.s1 = i_d;
        q_d.s2 = q_q.s1;
        q_d.s3 = q_q.s2;
        q_d.out = (q_q.out & (q_q.s2 ^ q_q.s3)) | (q_q.s3 & ~(q_q.s2 ^ q_q.s3));
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q_q <= '0;
        end else if (i_ce) begin
            q_q <= q_d;
        end
    end

    assign o_q = q_q.out;

endmodule : sync3

/* File: test_spi_config_lo_sequencer.sv */
// self-checking bench: register map, calibration, lock and lo controls.
// assumes 3-wire mode except one 4-wire read, and a CAL_CYCLES of 20 for short runs.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end

module test_spi_config_lo_sequencer import spi_cfg_pkg::*; ;
    logic clk_sys = 0, nrst = 1, lock = 0, sel0 = 0, sel1 = 0, sleep = 0, wire4 = 0;
    wire sclk, cs_n, mosi, mosi_en, sdio_w;
    logic sdio_o, sdio_oe, serial_data_out, sleep_m, lock_pin, busy, bias, dbuf, qdiv, di, dq, pi, pq, gate, io3v3;
    logic [1:0] rf_sel;
    logic [4:0] div;
    int bad_count = 0, n_tests = 0, n;
    logic [15:0] map [12] = '{ADDR_IO_LEVEL_LO, ADDR_LO_ENABLES, ADDR_PLL_POWER, ADDR_INT_LOW, ADDR_FB_DIV,
        ADDR_VCO_SEL, ADDR_CAL_CTL, ADDR_PFD_CP, ADDR_VCO_ADJ, ADDR_LOCK_STATUS, ADDR_IO_LEVEL_HI, ADDR_LO_OUT_CTL};
    logic [23:0] ext [7] = '{24'h120b_00, 24'h122d_00, 24'h1240_03, 24'h1217_00, 24'h121f_40, 24'h1021_d8,
        24'h1414_a1};

    // ***********************************************************************
    // clock, wire and instances
    // ***********************************************************************
    always #12.5 clk_sys = ~clk_sys;
    // released line shows the inverse of its last value, never a held copy
    assign sdio_w = sdio_oe ? sdio_o : (mosi_en ? mosi : ~mosi);

    spi_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .o_mosi_en(mosi_en),
        .i_miso(wire4 ? serial_data_out : sdio_w));

    spi_config_lo_sequencer #(.CAL_CYCLES(20)) dut (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_ce(1'b1),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_sdio(sdio_w), .o_sdio(sdio_o), .o_sdio_oe(sdio_oe),
        .o_serial_data_out(serial_data_out), .i_four_wire_mode(wire4), .i_loop_lock(lock), .i_rf_input_select_0(sel0),
        .i_rf_input_select_1(sel1), .i_sleep(sleep), .o_rf_path_sel(rf_sel), .o_sleep_mode(sleep_m),
        .o_lock_indicator_pin(lock_pin), .o_cal_busy(busy), .o_quad_bias_gen_ctl(bias),
        .o_divider_path_buffer_ctl(dbuf), .o_quadrature_divider_ctl(qdiv), .o_i_path_driver_en(di),
        .o_q_path_driver_en(dq), .o_i_path_predriver_en(pi), .o_q_path_predriver_en(pq),
        .o_lo_output_gate(gate), .o_lo_out_div(div), .o_io_level_3v3(io3v3));

    // ***********************************************************************
    // tasks
    // ***********************************************************************
    task automatic wait_sys(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : wait_sys

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer(1'b0, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] r;
        host.xfer(1'b1, a, 8'h00, r);
        `CHK(r, e)
    endtask : rd_chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // ***********************************************************************
    // scenarios
    // ***********************************************************************
    initial begin
        // a real falling edge, so the serial domain resets although its clock is still
        #1 nrst = 0;
        wait_sys(3);
        nrst = 1;
        sel1 = 1;
        sleep = 1;
        `CHK({bias, dbuf, qdiv}, 3'b111)
        for (int i = 0; i < 12; i++) rd_chk(map[i], map[i] == ADDR_LO_ENABLES ? RST_LO_ENABLES : RST_DEFAULT);
        for (int i = 0; i < 12; i++) wr(map[i], {i[3:0], ~i[3:0]});
        for (int i = 0; i < 12; i++) rd_chk(map[i], map[i] == ADDR_LOCK_STATUS ? 8'h00 : {i[3:0], ~i[3:0]});
        wr(16'h0001, 8'hff);
        rd_chk(16'h0001, 8'h00);
        `CHK(io3v3, 1'b0)
        wr(ADDR_IO_LEVEL_HI, 8'h10);
        wait_sys(10);
        `CHK(io3v3, 1'b1)
        `CHK({rf_sel, sleep_m}, 3'b101)
        wr(ADDR_LO_ENABLES, 8'h78);
        wait_sys(10);
        `CHK({pq, pi, dq, di, qdiv, dbuf, bias}, 7'b1111000)
        host.noise();
        rd_chk(ADDR_LO_ENABLES, 8'h78);
        wire4 = 1;
        rd_chk(ADDR_LO_ENABLES, 8'h78);
        wire4 = 0;
        // internal loop: calibration length, then lock on pin and register
        lock = 1;
        wr(ADDR_CAL_CTL, 8'h00);
        wr(ADDR_INT_LOW, 8'h40);
        n = 0;
        for (int k = 0; k < 200; k++) begin
            wait_sys(1);
            if (busy === 1'b1) n++;
            // lock left over from the earlier tracking phase must not end the count
            if (lock_pin === 1'b1 && busy === 1'b0 && n > 0) break;
        end
        `CHK(n, 20)
        `CHK(lock_pin, 1'b1)
        if (lock_pin !== 1'b1) wrap_up();
        rd_chk(ADDR_LOCK_STATUS, 8'h01);
        // external lo sequence disables calibration, then gate goes on last
        for (int i = 0; i < 7; i++) wr(ext[i][23:8], ext[i][7:0]);
        wr(ADDR_INT_LOW, 8'h40);
        wait_sys(8);
        `CHK({busy, gate, div}, 7'b0000001)
        wr(ADDR_LO_OUT_CTL, 8'he1);
        wait_sys(10);
        `CHK(gate, 1'b1)
        wrap_up();
    end
endmodule : test_spi_config_lo_sequencer
